// File: design/shift_rotate_table_mux_unit.sv
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "shift_rotate_defs.svh"

module shift_rotate_table_mux_unit (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic nrst_i,
    // AHB-Lite slave.
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic hready_i,
    input wire logic [31:0] hwdata_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Block flags.
    output shift_rotate_pkg::unit_flags_t flags_o
);
    import shift_rotate_pkg::*;

    // Effective size: zero acts as one, anything above the table acts as the full table.
    function automatic logic [`SIZE_W-1:0] eff_size(input logic [`SIZE_W-1:0] raw);
        logic [`SIZE_W-1:0] r;
        r = raw;
        if (raw == 7'h00) begin
            r = 7'h01;
        end else if (raw > 7'h40) begin
            r = 7'h40;
        end
        return r;
    endfunction

    // Bit mask covering the lowest size bits of the table.
    function automatic logic [`TBL_BITS-1:0] size_mask(input logic [`SIZE_W-1:0] sz);
        logic [`TBL_BITS-1:0] m;
        m = {`TBL_BITS{1'b1}} >> (7'h40 - sz);
        return m;
    endfunction

    // Registers.
    ahb_req_t req_ff;
    logic [3:0] ctrl_ff;
    logic [`SIZE_W-1:0] tsize_ff;
    logic [`TBL_BITS-1:0] table_ff;
    logic [`WORD_W-1:0] word_ff;
    logic [`CNT_W-1:0] rcount_ff;
    logic [`WORD_W-1:0] dest_ff;
    logic [`SIZE_W-1:0] msize_ff;
    logic [`WORD_W-1:0] mptr_ff;
    logic [`MEM_AW-1:0] taddr_ff;
    unit_flags_t flags_ff;
    logic [31:0] hrdata_ff;
    logic hreadyout_ff;
    logic hresp_ff;

    // Next values.
    ahb_req_t nxt_req;
    logic [3:0] nxt_ctrl;
    logic [`SIZE_W-1:0] nxt_tsize;
    logic [`TBL_BITS-1:0] nxt_table;
    logic [`WORD_W-1:0] nxt_word;
    logic [`CNT_W-1:0] nxt_rcount;
    logic [`WORD_W-1:0] nxt_dest;
    logic [`SIZE_W-1:0] nxt_msize;
    logic [`WORD_W-1:0] nxt_mptr;
    logic [`MEM_AW-1:0] nxt_taddr;
    unit_flags_t nxt_flags;
    logic [31:0] nxt_hrdata;

    // The register map, one aligned word per register, narrow fields in the low bits.
    // Offset 0x00 holds the table controls: enable, shift, direction (up when set) and data.
    // Offset 0x04 holds the table size; zero acts as one and anything above 64 as 64.
    // Offset 0x08 is the scan command: the operation in bits 2:0, its input in bit 8.
    // Offsets 0x0C and 0x10 read back the low and high halves of the bit table.
    // Offset 0x14 is the word register that the rotates use as source or operand.
    // Offset 0x18 is the rotate count; the multi rotates accept only one through sixteen.
    // Offset 0x1C is the destination of the multi rotates and of the selector.
    // Offset 0x20 is the selector table size, clamped the same way as the bit table.
    // Offset 0x24 is the selector pointer, kept as a full word so overruns are seen.
    // Offset 0x28 reads back the flags exactly as they leave the block.
    // Offset 0x2C is the write address into the word table.
    // Offset 0x30 writes one word into the table and reads back as zero.
    // Unmapped writes are dropped and unmapped reads return zero, always with OKAY.

    // Bus timing: the address phase is captured, and a write acts at the edge that
    // closes its data phase, because only then does the write data stand on the bus.
    // Reads are answered from registers loaded at the address phase edge, so the
    // slave never needs a wait state and back to back transfers are always legal.
    // A scan is simply a write to the scan command, so every operation acts at
    // most once per bus write; holding an input on means writing the command again.

    // Bus decode wires.
    wire addr_phase = hsel_i && htrans_i[1] && hready_i;
    wire wr = req_ff.valid && req_ff.write;
    wire wr_ctrl = wr && (req_ff.addr == `OFF_CTRL);
    wire wr_tsize = wr && (req_ff.addr == `OFF_TSIZE);
    wire wr_scan = wr && (req_ff.addr == `OFF_SCAN);
    wire wr_word = wr && (req_ff.addr == `OFF_WORD);
    wire wr_rcount = wr && (req_ff.addr == `OFF_RCOUNT);
    wire wr_dest = wr && (req_ff.addr == `OFF_DEST);
    wire wr_msize = wr && (req_ff.addr == `OFF_MSIZE);
    wire wr_mptr = wr && (req_ff.addr == `OFF_MPTR);
    wire wr_taddr = wr && (req_ff.addr == `OFF_TADDR);
    wire wr_tdata = wr && (req_ff.addr == `OFF_TDATA);

    // Scan command fields.
    wire op_t scan_op = op_t'(hwdata_i[2:0]);
    wire scan_in = hwdata_i[`SCAN_INPUT_BIT];
    wire run = wr_scan && scan_in;
    wire run_tshift = wr_scan && (scan_op == OP_TABLE_SHIFT);
    wire run_rrs = run && (scan_op == OP_ROT_RIGHT_SINGLE);
    wire run_rls = run && (scan_op == OP_ROT_LEFT_SINGLE);
    wire run_rrm = run && (scan_op == OP_ROT_RIGHT_MULTI);
    wire run_rlm = run && (scan_op == OP_ROT_LEFT_MULTI);
    wire run_sel = run && (scan_op == OP_TABLE_SELECT);
    wire idle_rot = wr_scan && !scan_in && (scan_op != OP_TABLE_SHIFT);

    // Table shifter controls.
    wire t_en = ctrl_ff[`CTRL_EN_BIT];
    wire t_shift = ctrl_ff[`CTRL_SHIFT_BIT];
    wire t_dir = ctrl_ff[`CTRL_DIR_BIT];
    wire t_data = ctrl_ff[`CTRL_DATA_BIT];
    wire [`SIZE_W-1:0] t_sz = eff_size(tsize_ff);
    wire [`TBL_BITS-1:0] t_mask = size_mask(t_sz);
    wire [`SIZE_W-1:0] t_top = t_sz - 7'h01;
    wire [`TBL_BITS-1:0] t_top_bit = {{(`TBL_BITS-1){1'b0}}, 1'b1} << t_top;
    wire t_step = run_tshift && t_en && t_shift;

    // Shifted tables; the data bit enters at the bottom going up, at the top going down.
    wire [`TBL_BITS-1:0] t_up = ({table_ff[`TBL_BITS-2:0], t_data}) & t_mask;
    wire [`TBL_BITS-1:0] t_down = ({1'b0, table_ff[`TBL_BITS-1:1]} & ~t_top_bit)
                                 | (t_data ? t_top_bit : {`TBL_BITS{1'b0}});
    wire t_out_up = table_ff[t_top[5:0]];
    wire t_out_down = table_ff[0];

    // Rotate operands and results.
    logic [`WORD_W-1:0] rot_res;
    wire cnt_ok = (rcount_ff >= `ROT_MIN) && (rcount_ff <= `ROT_MAX);
    wire rot_multi = run_rrm || run_rlm;
    wire [`WORD_W-1:0] rrs_res = {word_ff[0], word_ff[`WORD_W-1:1]};
    wire [`WORD_W-1:0] rls_res = {word_ff[`WORD_W-2:0], word_ff[`WORD_W-1]};

    word_rotator u_rot (
        .word_i(word_ff),
        .count_i(rcount_ff),
        .left_i(run_rlm),
        .result_o(rot_res)
    );

    // Table memory; the read address follows a pointer write on the same edge.
    logic [`WORD_W-1:0] mem_rdata;
    wire [`WORD_W-1:0] rd_ptr = wr_mptr ? hwdata_i[`WORD_W-1:0] : mptr_ff;
    wire [`SIZE_W-1:0] m_sz = eff_size(msize_ff);
    wire ptr_over = (mptr_ff >= {{(`WORD_W-`SIZE_W){1'b0}}, m_sz});

    table_mem u_mem (
        .clock_i(clock_i),
        .we_i(wr_tdata),
        .waddr_i(taddr_ff),
        .wdata_i(hwdata_i[`WORD_W-1:0]),
        .raddr_i(rd_ptr[`MEM_AW-1:0]),
        .rdata_o(mem_rdata)
    );

    // Bus request capture and plain register writes.
    assign nxt_req.valid = addr_phase;
    assign nxt_req.write = hwrite_i;
    assign nxt_req.addr = haddr_i[7:0];
    assign nxt_ctrl = wr_ctrl ? hwdata_i[3:0] : ctrl_ff;
    assign nxt_tsize = wr_tsize ? hwdata_i[`SIZE_W-1:0] : tsize_ff;
    assign nxt_rcount = wr_rcount ? hwdata_i[`CNT_W-1:0] : rcount_ff;
    assign nxt_msize = wr_msize ? hwdata_i[`SIZE_W-1:0] : msize_ff;
    assign nxt_mptr = rd_ptr;
    assign nxt_taddr = wr_taddr ? hwdata_i[`MEM_AW-1:0] : taddr_ff;

    // Bit table: cleared while disabled, one step per table-shift scan that sees shift on.
    always_comb begin
        nxt_table = table_ff;
        if (!t_en) begin
            nxt_table = {`TBL_BITS{1'b0}};
        end else if (t_step) begin
            nxt_table = t_dir ? t_up : t_down;
        end
    end

    // Word register: software write or single-bit rotate in place.
    always_comb begin
        nxt_word = word_ff;
        if (wr_word) begin
            nxt_word = hwdata_i[`WORD_W-1:0];
        end else if (run_rrs) begin
            nxt_word = rrs_res;
        end else if (run_rls) begin
            nxt_word = rls_res;
        end
    end

    // Destination: multi rotate result or selected table word.
    always_comb begin
        nxt_dest = dest_ff;
        if (wr_dest) begin
            nxt_dest = hwdata_i[`WORD_W-1:0];
        end else if (rot_multi && cnt_ok) begin
            nxt_dest = rot_res;
        end else if (run_sel && !ptr_over) begin
            nxt_dest = mem_rdata;
        end
    end

    // Flags: carry, table output, rotate output, selector output, count error.
    // The table and the rotates share one carry flag; a disabled table clears it on
    // every cycle, so software must keep the table enabled while it relies on the
    // carry left by a rotate.
    // A rotate in the same cycle as a table step wins the carry, since it is
    // written later in this process; one scan only ever names one operation, so
    // the two cannot both be asked for by a single command.
    // The rotate and selector outputs hold their value until the next scan of
    // their own kind; the rotate output is also cleared by a scan of operation
    // code 6 or 7 with its input off. This lets software read them back at leisure.
    always_comb begin
        nxt_flags = flags_ff;
        // The table output follows the top or bottom bit for the current direction.
        if (!t_en) begin
            nxt_flags.table_out = 1'b0;
            nxt_flags.carry_flag = 1'b0;
        end else begin
            nxt_flags.table_out = t_dir ? nxt_table[t_top[5:0]] : nxt_table[0];
            if (t_step) begin
                nxt_flags.carry_flag = t_dir ? t_out_up : t_out_down;
            end
        end
        // Rotates.
        if (run_rrs) begin
            nxt_flags.carry_flag = word_ff[0];
            nxt_flags.rot_out = rrs_res[0];
            nxt_flags.count_err = 1'b0;
        end else if (run_rls) begin
            nxt_flags.carry_flag = word_ff[`WORD_W-1];
            nxt_flags.rot_out = rls_res[`WORD_W-1];
            nxt_flags.count_err = 1'b0;
        end else if (rot_multi && cnt_ok) begin
            // The last bit carried round lands at the far end of the result.
            nxt_flags.carry_flag = run_rrm ? rot_res[`WORD_W-1] : rot_res[0];
            nxt_flags.rot_out = run_rrm ? rot_res[0] : rot_res[`WORD_W-1];
            nxt_flags.count_err = 1'b0;
        end else if (rot_multi) begin
            nxt_flags.rot_out = 1'b0;
            nxt_flags.count_err = 1'b1;
        end else if (idle_rot && (scan_op != OP_TABLE_SELECT)) begin
            nxt_flags.rot_out = 1'b0;
        end
        // Table selector.
        if (run_sel) begin
            nxt_flags.mux_out = ptr_over;
        end else if (idle_rot && (scan_op == OP_TABLE_SELECT)) begin
            nxt_flags.mux_out = 1'b0;
        end
    end

    // Read data for the coming data phase; unmapped addresses read zero.
    always_comb begin
        nxt_hrdata = 32'h0000_0000;
        if (addr_phase && !hwrite_i) begin
            case (haddr_i[7:0])
                `OFF_CTRL: nxt_hrdata = {28'h000_0000, ctrl_ff};
                `OFF_TSIZE: nxt_hrdata = {25'h000_0000, tsize_ff};
                `OFF_TLO: nxt_hrdata = table_ff[31:0];
                `OFF_THI: nxt_hrdata = table_ff[63:32];
                `OFF_WORD: nxt_hrdata = {16'h0000, word_ff};
                `OFF_RCOUNT: nxt_hrdata = {27'h000_0000, rcount_ff};
                `OFF_DEST: nxt_hrdata = {16'h0000, dest_ff};
                `OFF_MSIZE: nxt_hrdata = {25'h000_0000, msize_ff};
                `OFF_MPTR: nxt_hrdata = {16'h0000, mptr_ff};
                `OFF_STATUS: nxt_hrdata = {27'h000_0000, flags_ff};
                `OFF_TADDR: nxt_hrdata = {26'h000_0000, taddr_ff};
                default: nxt_hrdata = 32'h0000_0000;
            endcase
        end
    end

    // Bus side registers.
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            req_ff <= '0;
            hrdata_ff <= 32'h0000_0000;
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
        end else begin
            req_ff <= nxt_req;
            hrdata_ff <= nxt_hrdata;
            hreadyout_ff <= 1'b1; // Zero wait states.
            hresp_ff <= 1'b0; // Always OKAY.
        end
    end

    // Configuration registers.
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_ff <= 4'h0;
            tsize_ff <= `TSIZE_RST;
            rcount_ff <= `ROT_MIN;
            msize_ff <= `MSIZE_RST;
            mptr_ff <= 16'h0000;
            taddr_ff <= 6'h00;
        end else begin
            ctrl_ff <= nxt_ctrl;
            tsize_ff <= nxt_tsize;
            rcount_ff <= nxt_rcount;
            msize_ff <= nxt_msize;
            mptr_ff <= nxt_mptr;
            taddr_ff <= nxt_taddr;
        end
    end

    // Datapath state.
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            table_ff <= 64'h0000_0000_0000_0000;
            word_ff <= 16'h0000;
            dest_ff <= 16'h0000;
            flags_ff <= '0;
        end else begin
            table_ff <= nxt_table;
            word_ff <= nxt_word;
            dest_ff <= nxt_dest;
            flags_ff <= nxt_flags;
        end
    end

    // Outputs come straight from flip-flops.
    assign hrdata_o = hrdata_ff;
    assign hreadyout_o = hreadyout_ff;
    assign hresp_o = hresp_ff;
    assign flags_o = flags_ff;

endmodule // shift_rotate_table_mux_unit

// File: design/shift_rotate_defs.svh
`ifndef SHIFT_ROTATE_DEFS_SVH
`define SHIFT_ROTATE_DEFS_SVH

// Register byte offsets.
`define OFF_CTRL 8'h00
`define OFF_TSIZE 8'h04
`define OFF_SCAN 8'h08
`define OFF_TLO 8'h0C
`define OFF_THI 8'h10
`define OFF_WORD 8'h14
`define OFF_RCOUNT 8'h18
`define OFF_DEST 8'h1C
`define OFF_MSIZE 8'h20
`define OFF_MPTR 8'h24
`define OFF_STATUS 8'h28
`define OFF_TADDR 8'h2C
`define OFF_TDATA 8'h30

// Control register fields.
`define CTRL_EN_BIT 0
`define CTRL_SHIFT_BIT 1
`define CTRL_DIR_BIT 2
`define CTRL_DATA_BIT 3
// Scan command fields.
`define SCAN_INPUT_BIT 8
// Status register fields.
`define ST_CARRY_BIT 0
`define ST_TOUT_BIT 1
`define ST_ROUT_BIT 2
`define ST_MOUT_BIT 3
`define ST_CERR_BIT 4

// Sizes.
`define WORD_W 16
`define TBL_BITS 64
`define MEM_DEPTH 64
`define MEM_AW 6
`define SIZE_W 7
`define CNT_W 5
`define ROT_MIN 5'h01
`define ROT_MAX 5'h10

// Reset values.
`define TSIZE_RST 7'h40
`define MSIZE_RST 7'h40

`endif

// File: design/shift_rotate_pkg.sv
package shift_rotate_pkg;

    // Operation selected by a scan command.
    typedef enum logic [2:0] {
        OP_TABLE_SHIFT = 3'h0,
        OP_ROT_RIGHT_SINGLE = 3'h1,
        OP_ROT_LEFT_SINGLE = 3'h2,
        OP_ROT_RIGHT_MULTI = 3'h3,
        OP_ROT_LEFT_MULTI = 3'h4,
        OP_TABLE_SELECT = 3'h5
    } op_t;

    // Flags that leave the block.
    typedef struct packed {
        logic count_err;
        logic mux_out;
        logic rot_out;
        logic table_out;
        logic carry_flag;
    } unit_flags_t;

    // Captured AHB address phase.
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } ahb_req_t;

endpackage

// File: design/table_mem.sv
`timescale 1ns/10ps
`include "shift_rotate_defs.svh"

module table_mem (
    // Clock.
    input wire logic clock_i,
    // Write port.
    input wire logic we_i,
    input wire logic [`MEM_AW-1:0] waddr_i,
    input wire logic [`WORD_W-1:0] wdata_i,
    // Read port.
    input wire logic [`MEM_AW-1:0] raddr_i,
    output logic [`WORD_W-1:0] rdata_o
);

    logic [`WORD_W-1:0] mem [`MEM_DEPTH];

    // Write, and registered read that forwards a same-edge write.
    always_ff @(posedge clock_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        if (we_i && (waddr_i == raddr_i)) begin
            rdata_o <= wdata_i;
        end else begin
            rdata_o <= mem[raddr_i];
        end
    end

endmodule // table_mem

// File: design/word_rotator.sv
`timescale 1ns/10ps
`include "shift_rotate_defs.svh"

module word_rotator (
    // Operands.
    input wire logic [`WORD_W-1:0] word_i,
    input wire logic [`CNT_W-1:0] count_i,
    input wire logic left_i,
    // Result.
    output logic [`WORD_W-1:0] result_o
);

    logic [2*`WORD_W-1:0] dbl;
    logic [2*`WORD_W-1:0] shr;
    logic [2*`WORD_W-1:0] shl;

    // Doubling the word turns a plain shift into a rotation; count 16 gives the word back.
    assign dbl = {word_i, word_i};
    assign shr = dbl >> count_i;
    assign shl = dbl << count_i;
    assign result_o = left_i ? shl[2*`WORD_W-1:`WORD_W] : shr[`WORD_W-1:0];

endmodule // word_rotator

// File: sim/shift_rotate_table_mux_unit_checker.sv
`timescale 1ns/10ps
`include "shift_rotate_defs.svh"

module shift_rotate_table_mux_unit_checker
    import shift_rotate_pkg::*;
(
    // Clock and reset.
    input wire logic clock_i,
    input wire logic nrst_i,
    // Bus side.
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] hwdata_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    // Flags.
    input wire shift_rotate_pkg::unit_flags_t flags_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!nrst_i);

    // Shadows of the last address phase and of the registers the checks rely on.
    ahb_req_t ph_ff;
    logic en_ff;
    logic [4:0] cnt_ff;
    logic [6:0] msz_ff;
    logic [15:0] ptr_ff;

    // Decode of the current data phase, with the size clamp the selector uses.
    wire wr_dp = ph_ff.valid & ph_ff.write;
    wire scan = wr_dp & (ph_ff.addr == `OFF_SCAN);
    wire run = scan & hwdata_i[`SCAN_INPUT_BIT];
    wire [2:0] op = hwdata_i[2:0];
    wire cnt_ok = (cnt_ff >= `ROT_MIN) && (cnt_ff <= `ROT_MAX);
    wire [6:0] msz = (msz_ff == 7'h00) ? 7'h01 : ((msz_ff > 7'h40) ? 7'h40 : msz_ff);
    wire over = ptr_ff >= {9'h000, msz};

    // Register writes land at the data-phase edge, as in the block.
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ph_ff <= '0;
            en_ff <= 1'b0;
            cnt_ff <= 5'h01;
            msz_ff <= `MSIZE_RST;
            ptr_ff <= 16'h0000;
        end else begin
            ph_ff <= '{hsel_i & htrans_i[1] & hready_i, hwrite_i, haddr_i[7:0]};
            if (wr_dp && ph_ff.addr == `OFF_CTRL) en_ff <= hwdata_i[`CTRL_EN_BIT];
            if (wr_dp && ph_ff.addr == `OFF_RCOUNT) cnt_ff <= hwdata_i[4:0];
            if (wr_dp && ph_ff.addr == `OFF_MSIZE) msz_ff <= hwdata_i[6:0];
            if (wr_dp && ph_ff.addr == `OFF_MPTR) ptr_ff <= hwdata_i[15:0];
        end
    end

    a_ready_high: assert property (hreadyout_o)
        else $error("slave inserted a wait state");
    a_resp_okay: assert property (!hresp_o)
        else $error("slave gave an error response");
    a_rdata_quiet: assert property (!(ph_ff.valid && !ph_ff.write) |-> hrdata_o == 32'h0)
        else $error("read data outside a read data phase");
    a_table_clear: assert property (
        !en_ff && !$past(en_ff) && !$past(en_ff, 2) |-> !flags_o.carry_flag && !flags_o.table_out)
        else $error("table flags not cleared while disabled");
    a_count_reject: assert property (
        run && (op == 3'h3 || op == 3'h4) && !cnt_ok |=> flags_o.count_err && !flags_o.rot_out)
        else $error("bad rotate count accepted");
    a_rot_idle: assert property (
        scan && !hwdata_i[8] && op != 3'h0 && op < 3'h5
        |=> !flags_o.rot_out && $stable(flags_o.carry_flag))
        else $error("rotate acted with its input off");
    a_mux_over: assert property (run && op == 3'h5 && over |=> flags_o.mux_out)
        else $error("pointer overrun not flagged");
    a_mux_done: assert property (run && op == 3'h5 && !over |=> !flags_o.mux_out)
        else $error("selector flagged a good pointer");
    a_mux_idle: assert property (scan && !hwdata_i[8] && op == 3'h5 |=> !flags_o.mux_out)
        else $error("selector output high with input off");
endmodule // shift_rotate_table_mux_unit_checker

bind shift_rotate_table_mux_unit shift_rotate_table_mux_unit_checker u_chk (
    .clock_i(clock_i), .nrst_i(nrst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hwdata_i(hwdata_i),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .flags_o(flags_o)
);

// File: sim/tb_shift_rotate_table_mux_unit.sv
`timescale 1ns/10ps
`include "shift_rotate_defs.svh"

module tb_shift_rotate_table_mux_unit;
    import shift_rotate_pkg::*;

    // Design ports.
    logic clock_i;
    logic nrst_i;
    logic hsel_i;
    logic [31:0] haddr_i;
    logic [1:0] htrans_i;
    logic hwrite_i;
    logic [2:0] hsize_i;
    logic hready_i;
    logic [31:0] hwdata_i;
    logic [31:0] hrdata_o;
    logic hreadyout_o;
    logic hresp_o;
    unit_flags_t flags_o;
    // Counts and the expected state of the block.
    int bad_count;
    int check_count;
    logic [8:0] tbl;
    logic [15:0] word;
    logic [15:0] dest;
    logic carry, tout, rot, mux, cerr;
    logic [4:0] cnts [9] = '{5'h01, 5'h03, 5'h05, 5'h10, 5'h10, 5'h00, 5'h11, 5'h1F, 5'h07};
    logic [15:0] ptrs [6] = '{16'h0007, 16'h0000, 16'h0009, 16'h000A, 16'h003F, 16'hFFFF};

    // The one slave's ready is the bus ready.
    assign hready_i = hreadyout_o;

    shift_rotate_table_mux_unit uut (
        .clock_i(clock_i), .nrst_i(nrst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hready_i(hready_i),
        .hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o), .flags_o(flags_o)
    );

    // Free-running clock.
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    // Prints the counts and the verdict, then stops.
    task automatic summarize();
        $display("checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Compares one value.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // Waits for ready at a rising edge, with a bound.
    task automatic bus_wait();
        int n;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (hready_i !== 1'b1 && n < 50);
        if (hready_i !== 1'b1) begin
            bad_count++;
            $display("ERROR at %0t: bus wait ran out", $time);
            summarize();
        end
    endtask

    // One single word transfer: address phase, then data phase.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        hwrite_i <= w;
        haddr_i <= {24'h000000, a};
        hsize_i <= 3'h2;
        bus_wait();
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        bus_wait();
        q = hrdata_o;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask

    // One scan of an operation with its instruction input.
    task automatic scan(input logic [2:0] op, input logic on);
        wr(`OFF_SCAN, {23'h0, on, 5'h00, op});
    endtask

    function automatic logic [31:0] st();
        return {27'h0, cerr, mux, rot, tout, carry};
    endfunction

    // One table shift with the shift input held on.
    task automatic tshift(input logic up, input logic d);
        wr(`OFF_CTRL, {28'h0, d, up, 2'b11});
        scan(3'h0, 1'b0);
        carry = up ? tbl[8] : tbl[0];
        tbl = up ? {tbl[7:0], d} : {d, tbl[8:1]};
        tout = up ? tbl[8] : tbl[0];
        rd(`OFF_TLO, {23'h0, tbl});
        rd(`OFF_STATUS, st());
        check({27'h0, flags_o}, st());
    endtask

    // Rotate of n places; a count outside the range keeps dest and carry, sets the count error and clears the rotate output.
    task automatic rotn(input logic left, input logic [4:0] n);
        wr(`OFF_RCOUNT, {27'h0, n});
        scan(left ? 3'h4 : 3'h3, 1'b1);
        cerr = (n < 5'h01 || n > 5'h10);
        if (!cerr) begin
            dest = left ? ((word << n) | (word >> (16 - n))) : ((word >> n) | (word << (16 - n)));
            carry = left ? dest[0] : dest[15];
        end
        rot = !cerr && (left ? dest[15] : dest[0]);
        rd(`OFF_DEST, {16'h0, dest});
        rd(`OFF_STATUS, st());
        check({27'h0, flags_o}, st());
    endtask

    // Main sequence.
    initial begin
        nrst_i = 1'b0;
        hsel_i = 1'b0;
        haddr_i = 32'h0;
        htrans_i = 2'h0;
        hwrite_i = 1'b0;
        hsize_i = 3'h2;
        hwdata_i = 32'h0;
        bad_count = 0;
        check_count = 0;
        {tbl, word, dest, carry, tout, rot, mux, cerr} = '0;
        repeat (4) @(posedge clock_i);
        nrst_i <= 1'b1;
        @(posedge clock_i);
        rd(`OFF_TSIZE, 32'h40);
        rd(`OFF_MSIZE, 32'h40);
        rd(`OFF_RCOUNT, 32'h1);
        rd(`OFF_STATUS, 32'h0);
        wr(8'h40, 32'hFFFFFFFF);
        rd(8'h40, 32'h0);
        rd(`OFF_TDATA, 32'h0);
        wr(`OFF_TSIZE, 32'h9);
        for (int i = 0; i < 10; i++) tshift(1'b1, i[0] ^ i[3] ^ (i == 2));
        tshift(1'b0, 1'b1);
        tshift(1'b0, 1'b0);
        wr(`OFF_CTRL, 32'h5);
        scan(3'h0, 1'b1);
        tout = tbl[8];
        rd(`OFF_TLO, {23'h0, tbl});
        wr(`OFF_CTRL, 32'h0);
        rd(`OFF_TSIZE, 32'h9);
        {tbl, carry, tout} = '0;
        rd(`OFF_TLO, 32'h0);
        rd(`OFF_STATUS, st());
        wr(`OFF_CTRL, 32'h5);
        word = 16'hA5C3;
        wr(`OFF_WORD, {16'h0, word});
        for (int k = 0; k < 4; k++) begin
            scan(k[1] ? 3'h2 : 3'h1, 1'b1);
            carry = k[1] ? word[15] : word[0];
            word = k[1] ? {word[14:0], word[15]} : {word[0], word[15:1]};
            rot = k[1] ? word[15] : word[0];
            rd(`OFF_WORD, {16'h0, word});
            rd(`OFF_STATUS, st());
        end
        for (int k = 0; k < 9; k++) rotn(k[0], cnts[k]);
        scan(3'h1, 1'b0);
        rot = 1'b0;
        rd(`OFF_WORD, {16'h0, word});
        rd(`OFF_STATUS, st());
        for (int i = 0; i < 10; i++) begin
            wr(`OFF_TADDR, i);
            wr(`OFF_TDATA, 32'h1000 | i);
        end
        wr(`OFF_MSIZE, 32'hA);
        for (int k = 0; k < 6; k++) begin
            wr(`OFF_MPTR, {16'h0, ptrs[k]});
            scan(3'h5, 1'b1);
            mux = ptrs[k] >= 16'h000A;
            if (!mux) dest = 16'h1000 | ptrs[k];
            rd(`OFF_DEST, {16'h0, dest});
            rd(`OFF_STATUS, st());
        end
        scan(3'h5, 1'b0);
        mux = 1'b0;
        rd(`OFF_STATUS, st());
        summarize();
    end
endmodule // tb_shift_rotate_table_mux_unit
